// [hdl/iox_pkg.sv]
package iox_pkg;
    // register index within one port's group, same for both map layouts
    localparam logic [3:0] IDX_IODIR = 4'h0;
    localparam logic [3:0] IDX_IPOL = 4'h1;
    localparam logic [3:0] IDX_CHG_EN = 4'h2;
    localparam logic [3:0] IDX_DEFAULT_COMPARE_VALUE = 4'h3;
    localparam logic [3:0] IDX_SRC = 4'h4;
    localparam logic [3:0] IDX_CFG = 4'h5;
    localparam logic [3:0] IDX_PULLUP = 4'h6;
    localparam logic [3:0] IDX_FLAG = 4'h7;
    localparam logic [3:0] IDX_CAPTURE = 4'h8;
    localparam logic [3:0] IDX_PORT = 4'h9;
    localparam logic [3:0] IDX_OLAT = 4'hA;
    localparam logic [7:0] PAIRED_LAST = 8'h15;
    // configuration bit positions
    localparam int CFG_BANK = 7;
    localparam int CFG_MIRROR = 6;
    localparam int CFG_HOLD = 5;
    localparam int CFG_ODR = 2;
    localparam int CFG_POL = 1;
    localparam int CFG_CC = 0;
    localparam logic [7:0] CFG_IMPL_MASK = 8'hE7;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // returns {valid, port, index}
    function automatic logic [5:0] iox_decode(input logic [7:0] addr, input logic bank);
        logic ok;
        logic port;
        logic [3:0] idx;
        if (bank) begin
            port = addr[4];
            idx = addr[3:0];
            ok = (addr[7:5] == 3'h0) && (addr[3:0] <= IDX_OLAT);
        end else begin
            port = addr[0];
            idx = addr[4:1];
            ok = (addr <= PAIRED_LAST);
        end
        return {ok, port, idx};
    endfunction
endpackage

// [hdl/iox_sync3.sv]
module iox_sync3 (
    input wire logic i_clk, // system clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic [7:0] i_d, // raw pin levels
    output logic [7:0] o_q // settled pin levels
);
    logic [7:0] s1_reg;
    logic [7:0] s2_reg;
    logic [7:0] s3_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_reg <= 8'h00;
            s2_reg <= 8'h00;
            s3_reg <= 8'h00;
        end else begin
            s1_reg <= i_d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a bit moves only once two stages agree, filtering one-cycle glitches
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_q <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    o_q[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule

// [hdl/iox_chg_irq.sv]
module iox_chg_irq (
    input wire logic i_clk, // system clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic [7:0] i_pin, // settled pin levels
    input wire logic [7:0] i_en, // change interrupt enables
    input wire logic [7:0] i_def, // default compare bits
    input wire logic [7:0] i_src, // compare source bits
    input wire logic i_clr, // clearing read pulse
    output logic o_pending, // interrupt pending
    output logic [7:0] o_cap // pins captured at interrupt
);
    logic [7:0] prev_reg;
    logic [7:0] cond_def;
    logic [7:0] cond_prev;
    logic trig;

    assign cond_def = i_en & i_src & (i_pin ^ i_def);
    // previous-value compare is an event; frozen while pending
    assign cond_prev = i_en & ~i_src & (i_pin ^ prev_reg) & {8{~o_pending}};
    assign trig = |(cond_def | cond_prev);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_reg <= 8'h00;
        end else if (!o_pending || i_clr) begin
            prev_reg <= i_pin;
        end
    end

    // set wins over clear; a live default mismatch blocks the clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pending <= 1'b0;
        end else if (trig) begin
            o_pending <= 1'b1;
        end else if (i_clr) begin
            o_pending <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cap <= 8'h00;
        end else if (trig && !o_pending) begin
            o_cap <= i_pin;
        end
    end

    a_def_mismatch: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (|(i_en & i_src & (i_pin ^ i_def))) |=> o_pending)
        else $error("default mismatch did not raise interrupt");
    a_prev_change: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!o_pending && |(i_en & ~i_src & (i_pin ^ prev_reg))) |=> o_pending)
        else $error("pin change did not raise interrupt");
    a_clear_blocked: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_pending && i_clr && |cond_def) |=> o_pending)
        else $error("clear taken while condition active");
    a_pending_hold: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_pending && !i_clr) |=> o_pending)
        else $error("interrupt dropped without clearing read");
    a_disabled_quiet: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (!o_pending && i_en == 8'h00) |=> !o_pending)
        else $error("disabled pins raised interrupt");
endmodule

// [hdl/iox_cfg_regs.sv]
// Summary of operation
// - a default-compare pin differing from its default bit raises an interrupt
// - compare-source 1 compares with default bit, 0 with previous pin value
// - map layout 1 puts first port at 00h-0Ah, second at 10h-1Ah
// - map layout 0 interleaves the ports, second at next address; 00h-15h
// - a new map layout applies to the very next byte after the write
// - merge 1 drives both interrupt outputs from either port; 0 keeps them apart
// - pointer hold 1 keeps pointer fixed; 0 increments after every byte
// - open-drain 1 makes outputs open-drain, ignoring polarity; 0 drives actively
// - when actively driven, polarity 1 is active-high, 0 active-low
// - clear source 1 clears on capture read; 0 on port value read
// - a clearing read clears only when no default-compare mismatch remains; a previous-value change never blocks it
// - configuration bits 4 and 3 always read as zero
// - pull-up bit 1 enables the pin's pull-up, input or output
// - only pins with change interrupt enabled take part in detection
module iox_cfg_regs (
    input wire logic I_CLK_SYS, // system clock, 20 MHz
    input wire logic I_RST_N, // async reset, active low
    input wire logic I_PTR_LOAD, // load address pointer
    input wire logic [7:0] I_PTR_ADDR, // pointer value to load
    input wire logic I_WR_STB, // byte write at pointer
    input wire logic [7:0] I_WR_DATA, // byte to write
    input wire logic I_RD_STB, // byte read at pointer
    input wire logic [7:0] I_PIN_A, // first port pin levels
    input wire logic [7:0] I_PIN_B, // second port pin levels
    output logic [7:0] O_RD_DATA, // read byte
    output logic O_RD_VALID, // read byte valid pulse
    output logic [7:0] O_PTR, // current address pointer
    output logic [7:0] O_PULLUP_A, // first port pull-up enables
    output logic [7:0] O_PULLUP_B, // second port pull-up enables
    output logic O_IRQ_OUT_FIRST, // first interrupt pin level
    output logic O_IRQ_OUT_FIRST_OE, // first interrupt pin drive
    output logic O_IRQ_OUT_SECOND, // second interrupt pin level
    output logic O_IRQ_OUT_SECOND_OE // second interrupt pin drive
);
    logic [7:0] cfg_reg;
    logic [7:0] def_reg [2];
    logic [7:0] src_reg [2];
    logic [7:0] en_reg [2];
    logic [7:0] pu_reg [2];
    logic [7:0] pin_s [2];
    logic [7:0] cap [2];
    logic [1:0] pending;
    logic [1:0] clr;
    logic [5:0] dec;
    logic acc_ok;
    logic acc_port;
    logic [3:0] acc_idx;
    logic wr_go;
    logic rd_go;
    logic [7:0] rd_next;
    logic act_first;
    logic act_second;

    iox_sync3 u_sync_a (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .i_d(I_PIN_A),
        .o_q(pin_s[0])
    );

    iox_sync3 u_sync_b (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .i_d(I_PIN_B),
        .o_q(pin_s[1])
    );

    // layout taken from the live register, so a map change hits the next byte
    assign dec = iox_pkg::iox_decode(O_PTR, cfg_reg[iox_pkg::CFG_BANK]);
    assign acc_ok = dec[5];
    assign acc_port = dec[4];
    assign acc_idx = dec[3:0];
    // a pointer load owns its cycle; write beats read
    assign wr_go = I_WR_STB && !I_PTR_LOAD;
    assign rd_go = I_RD_STB && !I_WR_STB && !I_PTR_LOAD;

    // pointer moves after every byte, valid or not, unless held
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_PTR <= iox_pkg::RST_BYTE;
        end else if (I_PTR_LOAD) begin
            O_PTR <= I_PTR_ADDR;
        end else if ((wr_go || rd_go) && !cfg_reg[iox_pkg::CFG_HOLD]) begin
            O_PTR <= O_PTR + 8'h01;
        end
    end

    // shared register, visible at both of its addresses
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cfg_reg <= iox_pkg::RST_BYTE;
        end else if (wr_go && acc_ok && acc_idx == iox_pkg::IDX_CFG) begin
            cfg_reg <= I_WR_DATA & iox_pkg::CFG_IMPL_MASK;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            def_reg[0] <= iox_pkg::RST_BYTE;
            def_reg[1] <= iox_pkg::RST_BYTE;
        end else if (wr_go && acc_ok && acc_idx == iox_pkg::IDX_DEFAULT_COMPARE_VALUE) begin
            def_reg[acc_port] <= I_WR_DATA;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            src_reg[0] <= iox_pkg::RST_BYTE;
            src_reg[1] <= iox_pkg::RST_BYTE;
        end else if (wr_go && acc_ok && acc_idx == iox_pkg::IDX_SRC) begin
            src_reg[acc_port] <= I_WR_DATA;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            en_reg[0] <= iox_pkg::RST_BYTE;
            en_reg[1] <= iox_pkg::RST_BYTE;
        end else if (wr_go && acc_ok && acc_idx == iox_pkg::IDX_CHG_EN) begin
            en_reg[acc_port] <= I_WR_DATA;
        end
    end

    // pull-ups act regardless of pin direction
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pu_reg[0] <= iox_pkg::RST_BYTE;
            pu_reg[1] <= iox_pkg::RST_BYTE;
        end else if (wr_go && acc_ok && acc_idx == iox_pkg::IDX_PULLUP) begin
            pu_reg[acc_port] <= I_WR_DATA;
        end
    end

    assign O_PULLUP_A = pu_reg[0];
    assign O_PULLUP_B = pu_reg[1];

    // clearing read pulse per port, chosen by the clear-source bit
    always_comb begin
        clr = 2'b00;
        if (rd_go && acc_ok) begin
            if (cfg_reg[iox_pkg::CFG_CC]) begin
                clr[acc_port] = (acc_idx == iox_pkg::IDX_CAPTURE);
            end else begin
                clr[acc_port] = (acc_idx == iox_pkg::IDX_PORT);
            end
        end
    end

    iox_chg_irq u_irq_a (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .i_pin(pin_s[0]),
        .i_en(en_reg[0]),
        .i_def(def_reg[0]),
        .i_src(src_reg[0]),
        .i_clr(clr[0]),
        .o_pending(pending[0]),
        .o_cap(cap[0])
    );

    iox_chg_irq u_irq_b (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .i_pin(pin_s[1]),
        .i_en(en_reg[1]),
        .i_def(def_reg[1]),
        .i_src(src_reg[1]),
        .i_clr(clr[1]),
        .o_pending(pending[1]),
        .o_cap(cap[1])
    );

    // registers outside this group read as zero
    always_comb begin
        rd_next = 8'h00;
        if (acc_ok) begin
            unique case (acc_idx)
                iox_pkg::IDX_CHG_EN: rd_next = en_reg[acc_port];
                iox_pkg::IDX_DEFAULT_COMPARE_VALUE: rd_next = def_reg[acc_port];
                iox_pkg::IDX_SRC: rd_next = src_reg[acc_port];
                iox_pkg::IDX_CFG: rd_next = cfg_reg & iox_pkg::CFG_IMPL_MASK;
                iox_pkg::IDX_PULLUP: rd_next = pu_reg[acc_port];
                iox_pkg::IDX_CAPTURE: rd_next = cap[acc_port];
                iox_pkg::IDX_PORT: rd_next = pin_s[acc_port];
                default: rd_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_RD_DATA <= iox_pkg::RST_BYTE;
            O_RD_VALID <= 1'b0;
        end else begin
            O_RD_VALID <= rd_go;
            if (rd_go) begin
                O_RD_DATA <= rd_next;
            end
        end
    end

    assign act_first = pending[0] | (cfg_reg[iox_pkg::CFG_MIRROR] & pending[1]);
    assign act_second = pending[1] | (cfg_reg[iox_pkg::CFG_MIRROR] & pending[0]);

    // open-drain only pulls low when active; push-pull follows polarity
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_IRQ_OUT_FIRST <= 1'b0;
            O_IRQ_OUT_FIRST_OE <= 1'b0;
            O_IRQ_OUT_SECOND <= 1'b0;
            O_IRQ_OUT_SECOND_OE <= 1'b0;
        end else if (cfg_reg[iox_pkg::CFG_ODR]) begin
            O_IRQ_OUT_FIRST <= 1'b0;
            O_IRQ_OUT_FIRST_OE <= act_first;
            O_IRQ_OUT_SECOND <= 1'b0;
            O_IRQ_OUT_SECOND_OE <= act_second;
        end else begin
            O_IRQ_OUT_FIRST <= act_first ~^ cfg_reg[iox_pkg::CFG_POL];
            O_IRQ_OUT_FIRST_OE <= 1'b1;
            O_IRQ_OUT_SECOND <= act_second ~^ cfg_reg[iox_pkg::CFG_POL];
            O_IRQ_OUT_SECOND_OE <= 1'b1;
        end
    end

    a_ptr_advance: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        ((wr_go || rd_go) && !cfg_reg[iox_pkg::CFG_HOLD] && !(wr_go && acc_ok
            && acc_idx == iox_pkg::IDX_CFG)) |=> O_PTR == $past(O_PTR) + 8'h01)
        else $error("pointer did not advance after byte");
    a_ptr_hold: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        ((wr_go || rd_go) && cfg_reg[iox_pkg::CFG_HOLD] && !wr_go) |=> $stable(O_PTR))
        else $error("held pointer moved");
    a_bank_write: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (wr_go && acc_ok && acc_idx == iox_pkg::IDX_CFG)
            |=> cfg_reg[iox_pkg::CFG_BANK] == $past(I_WR_DATA[7]))
        else $error("map layout not updated after write");
    a_cfg_unimpl: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (rd_go && acc_ok && acc_idx == iox_pkg::IDX_CFG) |=> O_RD_VALID && O_RD_DATA[4:3] == 2'b00)
        else $error("unimplemented config bits read nonzero");
    a_bank_second: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (cfg_reg[iox_pkg::CFG_BANK] && O_PTR == 8'h13) |-> acc_ok && acc_port
            && acc_idx == iox_pkg::IDX_DEFAULT_COMPARE_VALUE)
        else $error("segregated map decode wrong");
    a_pair_second: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (!cfg_reg[iox_pkg::CFG_BANK] && O_PTR == 8'h07) |-> acc_ok && acc_port
            && acc_idx == iox_pkg::IDX_DEFAULT_COMPARE_VALUE)
        else $error("paired map decode wrong");
    a_mirror_join: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (cfg_reg[iox_pkg::CFG_MIRROR] && cfg_reg[iox_pkg::CFG_ODR] && |pending
            && $stable(cfg_reg)) |=> O_IRQ_OUT_FIRST_OE && O_IRQ_OUT_SECOND_OE)
        else $error("merged interrupt not on both outputs");
    a_irq_polarity: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (!cfg_reg[iox_pkg::CFG_ODR] && pending[0] && !cfg_reg[iox_pkg::CFG_POL]
            && $stable(cfg_reg)) |=> !O_IRQ_OUT_FIRST && O_IRQ_OUT_FIRST_OE)
        else $error("active-low interrupt not driven low");
    a_clear_route: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (rd_go && acc_ok && acc_idx == iox_pkg::IDX_PORT) |-> clr[acc_port]
            == !cfg_reg[iox_pkg::CFG_CC])
        else $error("port value read clear routing wrong");
endmodule

// [dv/iox_host.sv]
module iox_host (
    input wire logic i_clk, // system clock
    input wire logic [7:0] i_rd_data, // read byte
    input wire logic i_rd_valid, // read byte valid
    output logic o_ptr_load, // pointer load strobe
    output logic [7:0] o_ptr_addr, // pointer value
    output logic o_wr_stb, // write strobe
    output logic [7:0] o_wr_data, // write byte
    output logic o_rd_stb // read strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    // address and data only matter under their strobes, so only strobes start idle
    initial begin
        o_ptr_load = 1'b0;
        o_wr_stb = 1'b0;
        o_rd_stb = 1'b0;
    end

    task automatic point(input logic [7:0] a);
        @(negedge i_clk);
        o_ptr_load = 1'b1;
        o_ptr_addr = a;
        @(negedge i_clk);
        o_ptr_load = 1'b0;
        o_ptr_addr = ~a; // released value must not look still valid
    endtask

    // strobe held across bytes so the pointer steps once per byte
    task automatic put(input logic [7:0] d[$]);
        foreach (d[i]) begin
            @(negedge i_clk);
            o_wr_stb = 1'b1;
            o_wr_data = d[i];
        end
        @(negedge i_clk);
        o_wr_stb = 1'b0;
        o_wr_data = ~o_wr_data;
    endtask

    // layout changes go out as lone bytes so the pointer is never stranded
    task automatic put_cfg(input logic [7:0] a, input logic [7:0] v);
        point(a);
        put('{v});
    endtask

    task automatic get(output logic ok, output logic [7:0] d);
        @(negedge i_clk);
        o_rd_stb = 1'b1;
        @(negedge i_clk);
        o_rd_stb = 1'b0;
        ok = 1'b0;
        d = 8'hXX;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (i_rd_valid === 1'b1) begin
                ok = 1'b1;
                d = i_rd_data;
            end else begin
                @(negedge i_clk);
            end
        end
    endtask
endmodule

// [dv/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] pin_a = 8'h00;
    logic [7:0] pin_b = 8'h00;
    logic ptr_load, wr_stb, rd_stb, rd_valid;
    logic [7:0] ptr_addr, wr_data, rd_data, ptr, pu_a, pu_b;
    logic irq1, irq1_oe, irq2, irq2_oe;
    logic [7:0] cur_cfg = 8'h00;
    int bad_count = 0;
    int checks = 0;

    always #25 clk = ~clk;

    iox_host host (.i_clk(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
        .o_ptr_load(ptr_load), .o_ptr_addr(ptr_addr), .o_wr_stb(wr_stb),
        .o_wr_data(wr_data), .o_rd_stb(rd_stb));

    iox_cfg_regs dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PTR_LOAD(ptr_load),
        .I_PTR_ADDR(ptr_addr), .I_WR_STB(wr_stb), .I_WR_DATA(wr_data), .I_RD_STB(rd_stb),
        .I_PIN_A(pin_a), .I_PIN_B(pin_b), .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid),
        .O_PTR(ptr), .O_PULLUP_A(pu_a), .O_PULLUP_B(pu_b), .O_IRQ_OUT_FIRST(irq1),
        .O_IRQ_OUT_FIRST_OE(irq1_oe), .O_IRQ_OUT_SECOND(irq2),
        .O_IRQ_OUT_SECOND_OE(irq2_oe));

    task automatic cmp_byte(input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic cmp_irq(input logic [3:0] exp, input logic [3:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t irq exp=%h got=%h", $time, exp, got);
        end
    endtask

    // {drive, level}; level only matters while driving
    function automatic logic [1:0] pin_of(input logic act, input logic [7:0] cfg);
        if (cfg[2]) return {act, 1'b0};
        return {1'b1, act ~^ cfg[1]};
    endfunction

    function automatic logic [1:0] seen(input logic oe, input logic lvl);
        return {oe, (oe === 1'b1) ? lvl : 1'b0};
    endfunction

    task automatic chk_irq(input logic fa, input logic sa, input int wait_max);
        logic [3:0] exp;
        logic [3:0] got;
        exp = {pin_of(fa, cur_cfg), pin_of(sa, cur_cfg)};
        for (int i = 0; i <= wait_max; i++) begin
            got = {seen(irq1_oe, irq1), seen(irq2_oe, irq2)};
            if (got === exp) break;
            @(negedge clk);
        end
        cmp_irq(exp, got);
    endtask

    task automatic rd_at(input logic [7:0] a, input logic [7:0] exp);
        logic ok;
        logic [7:0] d;
        host.point(a);
        host.get(ok, d);
        cmp_byte(exp, d);
    endtask

    task automatic t_reset();
        cmp_byte(8'h00, pu_a);
        cmp_byte(8'h00, pu_b);
        // drive enables come up one edge after release
        chk_irq(1'b0, 1'b0, 2);
        rd_at(8'h0A, 8'h00);
        rd_at(8'h06, 8'h00);
        rd_at(8'h09, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_regs();
        logic [7:0] vals[4] = '{8'h5A, 8'hC3, 8'h96, 8'h69};
        host.point(8'h0C);
        host.put('{8'hA5, 8'h3C});
        cmp_byte(8'h0E, ptr);
        cmp_byte(8'hA5, pu_a);
        cmp_byte(8'h3C, pu_b);
        host.point(8'h06);
        host.put('{vals[0], vals[1], vals[2], vals[3]});
        for (int i = 0; i < 4; i++) rd_at(8'h06 + 8'(i), vals[i]);
        host.point(8'h16);
        host.put('{8'hFF});
        rd_at(8'h16, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_hold();
        logic ok;
        logic [7:0] d;
        host.put_cfg(8'h0A, 8'h38);
        cur_cfg = 8'h20;
        rd_at(8'h0A, 8'h20);
        host.point(8'h0C);
        repeat (2) begin
            host.get(ok, d);
            cmp_byte(8'hA5, d);
            cmp_byte(8'h0C, ptr);
        end
        host.put_cfg(8'h0A, 8'h00);
        cur_cfg = 8'h00;
        $display("test hold done");
    endtask

    task automatic t_bank();
        logic ok;
        logic [7:0] d;
        logic [7:0] adr[9] = '{8'h05, 8'h15, 8'h06, 8'h16, 8'h03, 8'h13, 8'h04, 8'h14, 8'h1B};
        logic [7:0] val[9] = '{8'h80, 8'h80, 8'hA5, 8'h3C, 8'h5A, 8'hC3, 8'h96, 8'h69, 8'h00};
        host.put_cfg(8'h0A, 8'h80);
        cur_cfg = 8'h80;
        cmp_byte(8'h0B, ptr);
        host.get(ok, d);
        cmp_byte(8'h00, d);
        for (int i = 0; i < 9; i++) rd_at(adr[i], val[i]);
        host.put_cfg(8'h05, 8'h00);
        cur_cfg = 8'h00;
        rd_at(8'h0D, 8'h3C);
        $display("test bank done");
    endtask

    task automatic t_irq_def();
        host.point(8'h04);
        host.put('{8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00});
        pin_a = 8'h02;
        repeat (12) @(negedge clk);
        chk_irq(1'b0, 1'b0, 0);
        pin_a = 8'h03;
        chk_irq(1'b1, 1'b0, 12);
        rd_at(8'h10, 8'h03);
        repeat (4) @(negedge clk);
        chk_irq(1'b1, 1'b0, 0);
        rd_at(8'h12, 8'h03);
        repeat (4) @(negedge clk);
        chk_irq(1'b1, 1'b0, 0);
        pin_a = 8'h02;
        repeat (8) @(negedge clk);
        rd_at(8'h12, 8'h02);
        chk_irq(1'b0, 1'b0, 6);
        host.put_cfg(8'h0A, 8'h01);
        cur_cfg = 8'h01;
        pin_a = 8'h03;
        chk_irq(1'b1, 1'b0, 12);
        pin_a = 8'h02;
        repeat (8) @(negedge clk);
        rd_at(8'h12, 8'h02);
        repeat (4) @(negedge clk);
        chk_irq(1'b1, 1'b0, 0);
        rd_at(8'h10, 8'h03);
        chk_irq(1'b0, 1'b0, 6);
        $display("test irq default done");
    endtask

    task automatic t_irq_prev();
        host.put_cfg(8'h0A, 8'h00);
        cur_cfg = 8'h00;
        host.point(8'h08);
        host.put('{8'h00});
        pin_a = 8'h03;
        chk_irq(1'b1, 1'b0, 12);
        rd_at(8'h12, 8'h03);
        chk_irq(1'b0, 1'b0, 6);
        pin_a = 8'h02;
        chk_irq(1'b1, 1'b0, 12);
        rd_at(8'h12, 8'h02);
        chk_irq(1'b0, 1'b0, 6);
        $display("test irq previous done");
    endtask

    task automatic t_out_modes();
        logic [7:0] cfgs[4] = '{8'h40, 8'h42, 8'h46, 8'h02};
        host.point(8'h04);
        host.put('{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01});
        foreach (cfgs[i]) begin
            host.put_cfg(8'h0A, cfgs[i]);
            cur_cfg = cfgs[i];
            chk_irq(1'b0, 1'b0, 4);
            pin_b = 8'h01;
            chk_irq(cfgs[i][6], 1'b1, 12);
            pin_b = 8'h00;
            repeat (8) @(negedge clk);
            rd_at(8'h13, 8'h00);
            chk_irq(1'b0, 1'b0, 6);
        end
        $display("test output modes done");
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("watchdog expired");
        close_out();
    end

    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_regs();
        t_hold();
        t_bank();
        t_irq_def();
        t_irq_prev();
        t_out_modes();
        close_out();
    end
endmodule
